/* File: bic_pkg.sv */
package bic_pkg;

   // Register byte offsets
   localparam logic [3:0] BIC_OFS_NORMAL_STATUS = 4'h0;
   localparam logic [3:0] BIC_OFS_NORMAL_CLEAR = 4'h0;
   localparam logic [3:0] BIC_OFS_NORMAL_ENABLE = 4'h4;
   localparam logic [3:0] BIC_OFS_FAST_STATUS = 4'h8;
   localparam logic [3:0] BIC_OFS_FAST_ENABLE = 4'hc;

   // Normal status bit positions
   localparam int BIC_NRM_SERIAL = 0;
   localparam int BIC_NRM_TIMER = 1;
   localparam int BIC_NRM_PARALLEL = 2;
   localparam int BIC_NRM_SLOT_LO = 3;
   localparam int BIC_NRM_PANIC = 7;

   // Fast status bit positions
   localparam int BIC_FST_SER_TX = 0;
   localparam int BIC_FST_SER_RX = 1;
   localparam int BIC_FST_DMA4 = 2;
   localparam int BIC_FST_NMI = 3;
   localparam int BIC_FST_DMA_LO = 4;

   // Synchroniser lane positions
   localparam int BIC_SYN_SLOT_LO = 0;
   localparam int BIC_SYN_PARALLEL = 4;
   localparam int BIC_SYN_SERIAL = 5;
   localparam int BIC_SYN_TIMER = 6;
   localparam int BIC_SYN_PANIC_N = 7;
   localparam int BIC_SYN_DMA_LO = 8;
   localparam int BIC_SYN_NMI = 13;
   localparam int BIC_SYN_SER_RX = 14;
   localparam int BIC_SYN_SER_TX = 15;
   localparam int BIC_SYN_W = 16;

   // Values after reset
   localparam logic [15:0] BIC_SYN_RST = 16'h0080;
   localparam logic BIC_PANIC_PREV_RST = 1'b1;
   localparam logic [6:0] BIC_NRM_EN_RST = 7'h00;
   localparam logic [7:0] BIC_FST_EN_RST = 8'h00;
   localparam logic [7:0] BIC_DATA_RST = 8'h00;

   // Processor access to the register file
   typedef struct packed {
      logic rd;
      logic wr;
      logic [3:0] addr;
      logic [7:0] wdata;
   } bic_io_req_s;

endpackage : bic_pkg

/* File: bic_top.sv */
// Summary of operation
// - Normal status read returns raw state of bits 6..2 and 0, unmasked; bits 7 and 1 are latched.
// - Normal interrupt is OR of status bits 6..0 ANDed with their enables, ORed with bit 7.
// - Status bit 7 latches on a low panic pulse, held until software clears.
// - Writing offset zero with bit 7 set clears the latched panic bit.
// - Timer bit 1 stays set until offset zero written with bit 1 set.
// - Panic always raises the normal interrupt, whatever the enable register holds.
// - Bits 6..3 follow slot lines 6..3; bit 2 parallel, bit 0 serial.
// - Normal enable bits 6..0 enable matching sources; cleared at reset.
// - Fast status read returns raw state of its eight fast requests.
// - Fast interrupt is OR of every fast status bit ANDed with enable.
// - Fast bits 7..4 DMA requests 3..0, 3 NMI, 2 DMA 4, 1 rx, 0 tx.
// - Fast enable bits 7..0 enable matching fast sources; cleared at reset.
// - Decode: status/clear at 0, normal enable 4, fast status 8, fast enable C.
`timescale 1ns/1ns
`default_nettype none
module bic_top
   import bic_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Processor register access
   input wire bic_io_req_s io_req,
   output logic [7:0] io_rdata,
   output logic io_rvalid,
   // Normal interrupt sources
   input wire logic [6:3] slot_irq,
   input wire logic parallel_irq,
   input wire logic serial_irq,
   input wire logic timer_irq,
   input wire logic panic_n,
   // Fast interrupt sources
   input wire logic [4:0] pseudo_dma_request,
   input wire logic analyzer_nmi,
   input wire logic serial_receive_dma_request,
   input wire logic serial_transmit_dma_request,
   // Processor interrupt outputs
   output logic normal_interrupt,
   output logic fast_interrupt
);

   logic [BIC_SYN_W-1:0] raw_in;
   logic [BIC_SYN_W-1:0] sync1_d;
   logic [BIC_SYN_W-1:0] sync1_q;
   logic [BIC_SYN_W-1:0] sync2_d;
   logic [BIC_SYN_W-1:0] sync2_q;
   logic panic_prev_d;
   logic panic_prev_q;
   logic panic_d;
   logic panic_q;
   logic timer_d;
   logic timer_q;
   logic [6:0] nrm_en_d;
   logic [6:0] nrm_en_q;
   logic [7:0] fst_en_d;
   logic [7:0] fst_en_q;
   logic [7:0] nrm_status;
   logic [7:0] fst_status;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic rvalid_d;
   logic rvalid_q;
   logic nirq_d;
   logic nirq_q;
   logic firq_d;
   logic firq_q;
   logic clr_wr;

   // Gather asynchronous inputs
   always_comb begin
      raw_in = '0;
      raw_in[BIC_SYN_SLOT_LO +: 4] = slot_irq;
      raw_in[BIC_SYN_PARALLEL] = parallel_irq;
      raw_in[BIC_SYN_SERIAL] = serial_irq;
      raw_in[BIC_SYN_TIMER] = timer_irq;
      raw_in[BIC_SYN_PANIC_N] = panic_n;
      raw_in[BIC_SYN_DMA_LO +: 5] = pseudo_dma_request;
      raw_in[BIC_SYN_NMI] = analyzer_nmi;
      raw_in[BIC_SYN_SER_RX] = serial_receive_dma_request;
      raw_in[BIC_SYN_SER_TX] = serial_transmit_dma_request;
   end

   // Two flop synchronisers, one per lane
   genvar gi;
   generate
      for (gi = 0; gi < BIC_SYN_W; gi++) begin : g_sync
         always_comb begin
            sync1_d[gi] = raw_in[gi];
            sync2_d[gi] = sync1_q[gi];
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= BIC_SYN_RST;
         sync2_q <= BIC_SYN_RST;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
      end
   end

   assign clr_wr = io_req.wr && (io_req.addr == BIC_OFS_NORMAL_CLEAR);

   // Sticky panic and timer bits, set wins over clear
   always_comb begin
      panic_prev_d = sync2_q[BIC_SYN_PANIC_N];
      panic_d = panic_q;
      timer_d = timer_q;
      if (clr_wr && io_req.wdata[BIC_NRM_PANIC]) begin
         panic_d = 1'b0;
      end
      if (clr_wr && io_req.wdata[BIC_NRM_TIMER]) begin
         timer_d = 1'b0;
      end
      if (panic_prev_q && !sync2_q[BIC_SYN_PANIC_N]) begin
         panic_d = 1'b1;
      end
      if (sync2_q[BIC_SYN_TIMER]) begin
         timer_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         panic_prev_q <= BIC_PANIC_PREV_RST;
         panic_q <= 1'b0;
         timer_q <= 1'b0;
      end else begin
         panic_prev_q <= panic_prev_d;
         panic_q <= panic_d;
         timer_q <= timer_d;
      end
   end

   // Raw status vectors
   always_comb begin
      nrm_status = '0;
      nrm_status[BIC_NRM_PANIC] = panic_q;
      nrm_status[BIC_NRM_SLOT_LO +: 4] = sync2_q[BIC_SYN_SLOT_LO +: 4];
      nrm_status[BIC_NRM_PARALLEL] = sync2_q[BIC_SYN_PARALLEL];
      nrm_status[BIC_NRM_TIMER] = timer_q;
      nrm_status[BIC_NRM_SERIAL] = sync2_q[BIC_SYN_SERIAL];
      fst_status = '0;
      fst_status[BIC_FST_DMA_LO +: 4] = sync2_q[BIC_SYN_DMA_LO +: 4];
      fst_status[BIC_FST_NMI] = sync2_q[BIC_SYN_NMI];
      fst_status[BIC_FST_DMA4] = sync2_q[BIC_SYN_DMA_LO + 4];
      fst_status[BIC_FST_SER_RX] = sync2_q[BIC_SYN_SER_RX];
      fst_status[BIC_FST_SER_TX] = sync2_q[BIC_SYN_SER_TX];
   end

   // Enable registers and read port
   always_comb begin
      nrm_en_d = nrm_en_q;
      fst_en_d = fst_en_q;
      rvalid_d = io_req.rd;
      rdata_d = BIC_DATA_RST;
      if (io_req.wr && (io_req.addr == BIC_OFS_NORMAL_ENABLE)) begin
         nrm_en_d = io_req.wdata[6:0];
      end
      if (io_req.wr && (io_req.addr == BIC_OFS_FAST_ENABLE)) begin
         fst_en_d = io_req.wdata;
      end
      if (io_req.rd) begin
         unique case (io_req.addr)
            BIC_OFS_NORMAL_STATUS: rdata_d = nrm_status;
            BIC_OFS_FAST_STATUS: rdata_d = fst_status;
            default: rdata_d = BIC_DATA_RST;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         nrm_en_q <= BIC_NRM_EN_RST;
         fst_en_q <= BIC_FST_EN_RST;
         rdata_q <= BIC_DATA_RST;
         rvalid_q <= 1'b0;
      end else begin
         nrm_en_q <= nrm_en_d;
         fst_en_q <= fst_en_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Interrupt combination
   always_comb begin
      nirq_d = |(nrm_status[6:0] & nrm_en_q)
         | nrm_status[BIC_NRM_PANIC];
      firq_d = |(fst_status & fst_en_q);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         nirq_q <= 1'b0;
         firq_q <= 1'b0;
      end else begin
         nirq_q <= nirq_d;
         firq_q <= firq_d;
      end
   end

   assign normal_interrupt = nirq_q;
   assign fast_interrupt = firq_q;
   assign io_rdata = rdata_q;
   assign io_rvalid = rvalid_q;

endmodule : bic_top
`default_nettype wire

/* File: bic_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module bic_sva
   import bic_pkg::*;
(
   // Watched ports
   input wire logic clk, input wire logic rst,
   input wire bic_io_req_s io_req,
   input wire logic [7:0] io_rdata, input wire logic io_rvalid,
   input wire logic [6:3] slot_irq, input wire logic parallel_irq,
   input wire logic serial_irq, input wire logic timer_irq, input wire logic panic_n,
   input wire logic [4:0] pseudo_dma_request, input wire logic analyzer_nmi,
   input wire logic serial_receive_dma_request,
   input wire logic serial_transmit_dma_request,
   input wire logic normal_interrupt, input wire logic fast_interrupt
);
   logic [2:0] ok_q;
   logic [7:0] fv;
   logic [7:0] nv;
   assign fv = {pseudo_dma_request[3:0], analyzer_nmi, pseudo_dma_request[4],
      serial_receive_dma_request, serial_transmit_dma_request};
   assign nv = {1'b0, slot_irq, parallel_irq, 1'b0, serial_irq};
   always_ff @(posedge clk) ok_q <= rst ? 3'h0 : {ok_q[1:0], 1'b1};
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_rv; io_req.rd |=> io_rvalid; endproperty
   a_rv: assert property (p_rv) else $error("read not answered");
   property p_rv0; !io_req.rd |=> !io_rvalid; endproperty
   a_rv0: assert property (p_rv0) else $error("stray read answer");
   property p_idle; !io_req.rd |=> io_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_wo; io_req.rd && !(io_req.addr inside {4'h0, 4'h8}) |=> io_rdata == 8'h00;
   endproperty
   a_wo: assert property (p_wo) else $error("write-only place read back");
   property p_fst;
      io_req.rd && io_req.addr == 4'h8 && ok_q[2] && fv == $past(fv) && fv == $past(fv, 2)
         && fv == $past(fv, 3) |=> io_rdata == $past(fv);
   endproperty
   a_fst: assert property (p_fst) else $error("fast status wrong");
   property p_nst;
      io_req.rd && io_req.addr == 4'h0 && ok_q[2] && nv == $past(nv) && nv == $past(nv, 2)
         && nv == $past(nv, 3) |=> (io_rdata & 8'h7d) == $past(nv);
   endproperty
   a_nst: assert property (p_nst) else $error("normal status wrong");
   property p_fiq; fast_interrupt |-> $past(fv, 3) != 8'h00; endproperty
   a_fiq: assert property (p_fiq) else $error("fast interrupt without source");
   property p_pan; $fell(panic_n) ##1 !panic_n [*3] |-> ##[0:3] normal_interrupt;
   endproperty
   a_pan: assert property (p_pan) else $error("panic not raised");
   c_ni: cover property (normal_interrupt);
   c_fi: cover property (fast_interrupt);
   c_clr: cover property (io_req.wr && io_req.addr == 4'h0);
endmodule : bic_sva
bind bic_top bic_sva u_sva (.clk, .rst, .io_req, .io_rdata, .io_rvalid, .slot_irq,
   .parallel_irq, .serial_irq, .timer_irq, .panic_n, .pseudo_dma_request, .analyzer_nmi,
   .serial_receive_dma_request, .serial_transmit_dma_request, .normal_interrupt,
   .fast_interrupt);
`default_nettype wire

/* File: bic_src_model.sv */
`timescale 1ns/1ns
`default_nettype none
module bic_src_model (
   // Requests in status bit order
   input wire logic [7:0] nv,
   input wire logic [7:0] fv,
   // Source lines
   output logic [6:3] slot_irq,
   output logic parallel_irq,
   output logic serial_irq,
   output logic timer_irq,
   output logic panic_n,
   output logic [4:0] pseudo_dma_request,
   output logic analyzer_nmi,
   output logic serial_receive_dma_request,
   output logic serial_transmit_dma_request
);
   assign slot_irq = nv[6:3];
   assign parallel_irq = nv[2];
   assign timer_irq = nv[1];
   assign serial_irq = nv[0];
   assign panic_n = ~nv[7];
   assign pseudo_dma_request = {fv[2], fv[7:4]};
   assign analyzer_nmi = fv[3];
   assign serial_receive_dma_request = fv[1];
   assign serial_transmit_dma_request = fv[0];
endmodule : bic_src_model
`default_nettype wire

/* File: board_interrupt_controller_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module board_interrupt_controller_bench;
   import bic_pkg::*;
   logic clk = 0, rst = 1, io_rvalid, parallel_irq, serial_irq, timer_irq, panic_n;
   logic analyzer_nmi, serial_receive_dma_request, serial_transmit_dma_request, ni, fi;
   logic [7:0] io_rdata, nv = 8'h00, fv = 8'h00;
   logic [6:3] slot_irq;
   logic [4:0] pseudo_dma_request;
   bic_io_req_s io_req = '0;
   int fails = 0, tests_run = 0, cyc = 0;
   bic_src_model src (.nv, .fv, .slot_irq, .parallel_irq, .serial_irq, .timer_irq, .panic_n,
      .pseudo_dma_request, .analyzer_nmi, .serial_receive_dma_request,
      .serial_transmit_dma_request);
   bic_top dut (.clk, .rst, .io_req, .io_rdata, .io_rvalid, .slot_irq, .parallel_irq,
      .serial_irq, .timer_irq, .panic_n, .pseudo_dma_request, .analyzer_nmi,
      .serial_receive_dma_request, .serial_transmit_dma_request, .normal_interrupt(ni),
      .fast_interrupt(fi));
   always #2 clk = ~clk;
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         fails++;
         tally_and_finish();
      end
   end
   task chk(input logic [7:0] s, input logic [7:0] e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge clk) io_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge clk) io_req.wr = 1'b0;
   endtask : wr
   task rd(input logic [3:0] a, input logic [7:0] e);
      @(negedge clk) io_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge clk) io_req.rd = 1'b0;
      chk({7'h00, io_rvalid}, 8'h01);
      chk(io_rdata, e);
   endtask : rd
   task gap;
      repeat (5) @(negedge clk);
   endtask : gap
   initial begin
      repeat (8) @(negedge clk);
      rst = 0;
      rd(4'h4, 8'h00);
      rd(4'hc, 8'h00);
      rd(4'h2, 8'h00);
      fv = 8'hff;
      nv = 8'h7d;
      gap();
      chk({6'h00, ni, fi}, 8'h00);
      rd(4'h0, 8'h7d);
      rd(4'h8, 8'hff);
      for (int i = 0; i < 8; i++) begin
         fv = 8'h01 << i;
         nv = 8'h00;
         gap();
         rd(4'h8, fv);
         wr(4'hc, fv);
         gap();
         chk({7'h00, fi}, 8'h01);
         wr(4'hc, ~fv);
         gap();
         chk({7'h00, fi}, 8'h00);
         if (i != 1 && i != 7) begin
            nv = fv;
            gap();
            rd(4'h0, nv);
            wr(4'h4, nv);
            gap();
            chk({7'h00, ni}, 8'h01);
            wr(4'h4, ~nv);
            gap();
            chk({7'h00, ni}, 8'h00);
         end
      end
      fv = 8'h00;
      nv = 8'h02;
      gap();
      nv = 8'h00;
      gap();
      rd(4'h0, 8'h02);
      wr(4'h0, 8'h02);
      rd(4'h0, 8'h00);
      wr(4'h4, 8'h00);
      nv = 8'h80;
      repeat (4) @(negedge clk);
      nv = 8'h00;
      gap();
      chk({7'h00, ni}, 8'h01);
      rd(4'h0, 8'h80);
      wr(4'h0, 8'h80);
      gap();
      rd(4'h0, 8'h00);
      chk({7'h00, ni}, 8'h00);
      tally_and_finish();
   end
endmodule : board_interrupt_controller_bench
`default_nettype wire
